// *** src/hbgs_sequencer.sv ***
// Gate drive sequencer for three half-bridges, static and pulse operation
`timescale 1ns/1ps

module hbgs_sequencer
  import hbgs_pkg::*;
#(
  parameter int NHB = HBGS_NHB
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Serial port chip select pin
  input  wire logic                    cs_b,
  // Global configuration
  input  wire logic                    gate_supply_on,
  input  wire logic                    hold_current_sel,
  input  wire logic                    active_freewheel_detect_on,
  input  wire logic                    pulse_input_count_sel,
  input  wire logic                    postcharge_off,
  input  wire logic [1:0]              gate_control_scheme,
  input  wire logic [1:0]              bridge_driver_clock_sel,
  // Per-bridge configuration
  input  wire logic [1:0]              bridge_state_select      [NHB],
  input  wire logic [NHB-1:0]          bridge_pulse_drive_on,
  input  wire logic [NHB-1:0]          active_freewheel_on,
  input  wire logic [3:0]              static_drive_current_sel [NHB],
  input  wire hbgs_timing_s            timing                   [NHB],
  input  wire hbgs_level_s             levels                   [NHB],
  // Pins and comparators
  input  wire logic [NHB-1:0]          pulse_in,
  input  wire logic [NHB-1:0]          switch_node_high,
  input  wire logic [NHB-1:0]          switch_node_low,
  input  wire logic [NHB-1:0]          turn_on_late,
  input  wire logic [NHB-1:0]          turn_off_late,
  // Gate drive outputs
  output hbgs_drive_s                  hs_drive                 [NHB],
  output hbgs_drive_s                  ls_drive                 [NHB],
  output logic [NHB-1:0]               sequence_busy
);

  localparam int SW = 1 + 5 * NHB;

  if (NHB < 1 || NHB > 8) begin : g_chk_nhb
    $error("hbgs_sequencer: NHB must be 1 to 8");
  end
  if (HBGS_CMD_LAT_CYC > HBGS_CMD_DELAY_CYC) begin : g_chk_lat
    $error("hbgs_sequencer: command latency exceeds bound");
  end

  // Two-flop synchroniser for every pin input
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic          cs_prev_ff;
  wire  [SW-1:0] raw_in = {turn_off_late, turn_on_late, switch_node_low, switch_node_high, pulse_in, cs_b};

  // Reset to the pins' idle levels: chip select high, all others low, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff   <= {{(SW-1){1'b0}}, 1'b1};
      sync2_ff   <= {{(SW-1){1'b0}}, 1'b1};
      cs_prev_ff <= 1'b1;
    end else begin
      sync1_ff   <= raw_in;
      sync2_ff   <= sync1_ff;
      cs_prev_ff <= sync2_ff[0];
    end
  end

  wire           cs_s      = sync2_ff[0];
  wire [NHB-1:0] pulse_s   = sync2_ff[NHB:1];
  wire [NHB-1:0] sw_high_s = sync2_ff[2*NHB:NHB+1];
  wire [NHB-1:0] sw_low_s  = sync2_ff[3*NHB:2*NHB+1];
  wire [NHB-1:0] on_late_s = sync2_ff[4*NHB:3*NHB+1];
  wire [NHB-1:0] off_late_s = sync2_ff[5*NHB:4*NHB+1];
  wire           cs_rise   = cs_s & ~cs_prev_ff;

  // Command capture; keeps the whole frame atomic to the sequencers
  logic [1:0] cmd_mode_ff [NHB];
  logic       cmd_ev_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_ev_ff <= 1'b0;
      for (int i = 0; i < NHB; i++) begin
        cmd_mode_ff[i] <= HBGS_MODE_PASSIVE;
      end
    end else begin
      cmd_ev_ff <= cs_rise;
      if (cs_rise) begin
        for (int i = 0; i < NHB; i++) begin
          cmd_mode_ff[i] <= bridge_state_select[i];
        end
      end
    end
  end

  // Bridge driver clock tick, period 2 to 16 cycles
  logic [HBGS_BD_W-1:0] bd_cnt_ff;
  logic                 bd_tick_ff;
  wire  [HBGS_BD_W-1:0] bd_mask = {bridge_driver_clock_sel == 2'h3, bridge_driver_clock_sel >= 2'h2,
                                   bridge_driver_clock_sel >= 2'h1, 1'b1};
  wire                  bd_wrap = &(bd_cnt_ff | ~bd_mask);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bd_cnt_ff  <= HBGS_BD_RST;
      bd_tick_ff <= 1'b0;
    end else begin
      bd_cnt_ff  <= bd_cnt_ff + HBGS_BD_W'(1);
      bd_tick_ff <= bd_wrap;
    end
  end

  wire [HBGS_LVL_W-1:0] hold_lvl  = hold_current_sel ? HBGS_LVL_HOLD_HIGH : HBGS_LVL_HOLD_LOW;
  wire                  pre_on    = gate_control_scheme != HBGS_GCS_NONE;
  wire                  adapt_on  = gate_control_scheme[HBGS_GCS_ADAPT];

  for (genvar g = 0; g < NHB; g++) begin : g_hb
    hbgs_state_e           st_ff,       nxt_st;
    logic [HBGS_CNT_W-1:0] cnt_ff,      nxt_cnt;
    logic                  side_ff,     nxt_side;
    logic                  on_hs_ff,    nxt_on_hs;
    logic                  on_ls_ff,    nxt_on_ls;
    logic                  passive_ff,  nxt_passive;
    logic                  offseq_ff,   nxt_offseq;
    logic                  fwpend_ff,   nxt_fwpend;
    logic [HBGS_LVL_W-1:0] lvl_ff,      nxt_lvl;
    logic [HBGS_LVL_W-1:0] pre_lvl_ff,  nxt_pre_lvl;
    logic [HBGS_LVL_W-1:0] pdis_lvl_ff, nxt_pdis_lvl;
    logic                  pulse_d_ff;
    hbgs_drive_s           hs_ff,       nxt_hs;
    hbgs_drive_s           ls_ff,       nxt_ls;
    hbgs_drive_s           on_drv;
    hbgs_drive_s           off_drv;
    logic                  busy_ff;

    wire [1:0]            mode      = cmd_mode_ff[g];
    wire                  mode_on   = (mode == HBGS_MODE_HS_ON) || (mode == HBGS_MODE_LS_ON);
    wire                  pwm_mode  = bridge_pulse_drive_on[g] & mode_on;
    wire                  afw_eff   = active_freewheel_on[g] & bridge_pulse_drive_on[g]
                                      & ~pulse_input_count_sel;
    wire                  p_rise    = pwm_mode & pulse_s[g] & ~pulse_d_ff;
    wire                  p_fall    = pwm_mode & ~pulse_s[g] & pulse_d_ff;
    wire                  pwm_side  = mode == HBGS_MODE_HS_ON;
    // Node near supply: low-side active; near ground: high-side active
    wire                  det_side  = sw_high_s[g] ? 1'b0 : (sw_low_s[g] ? 1'b1 : pwm_side);
    wire                  act_side  = active_freewheel_detect_on ? det_side : pwm_side;
    wire                  opp_on    = act_side ? on_ls_ff : on_hs_ff;
    wire                  cmd_opp   = pwm_side ? on_ls_ff : on_hs_ff;
    wire [HBGS_CNT_W-1:0] dur_ccp   = {1'b0, timing[g].ccp};
    wire [HBGS_CNT_W-1:0] dur_blank = {1'b0, timing[g].blank};
    wire [HBGS_CNT_W-1:0] dur_pre   = {1'b0, timing[g].pre};
    wire [HBGS_CNT_W-1:0] dur_pdis  = {1'b0, timing[g].pdis};
    wire [HBGS_CNT_W-1:0] dur_chg   = dur_blank + {1'b0, timing[g].filter};
    wire                  done      = cnt_ff <= HBGS_CNT_ONE;
    wire [HBGS_LVL_W-1:0] st_lvl    = {static_drive_current_sel[g], HBGS_STATIC_PAD};
    wire [HBGS_LVL_W-1:0] max_lvl   = levels[g].max;
    wire [HBGS_LVL_W-1:0] pre_cur   = adapt_on ? pre_lvl_ff : levels[g].pre_init;
    wire [HBGS_LVL_W-1:0] pdis_cur  = adapt_on ? pdis_lvl_ff : levels[g].pdis_init;
    // Adaptation steps stay between the minimum code and the bridge maximum
    wire [HBGS_LVL_W-1:0] pre_up    = (pre_lvl_ff >= max_lvl) ? max_lvl : pre_lvl_ff + HBGS_LVL_STEP;
    wire [HBGS_LVL_W-1:0] pre_dn    = (pre_lvl_ff == HBGS_LVL_MIN) ? HBGS_LVL_MIN : pre_lvl_ff - HBGS_LVL_STEP;
    wire [HBGS_LVL_W-1:0] pdis_up   = (pdis_lvl_ff >= max_lvl) ? max_lvl : pdis_lvl_ff + HBGS_LVL_STEP;
    wire [HBGS_LVL_W-1:0] pdis_dn   = (pdis_lvl_ff == HBGS_LVL_MIN) ? HBGS_LVL_MIN : pdis_lvl_ff - HBGS_LVL_STEP;
    wire [HBGS_CNT_W-1:0] cnt_dec   = (cnt_ff == HBGS_CNT_RST) ? HBGS_CNT_RST : cnt_ff - HBGS_CNT_ONE;

    always_comb begin
      nxt_st       = st_ff;
      nxt_cnt      = cnt_dec;
      nxt_side     = side_ff;
      nxt_on_hs    = on_hs_ff;
      nxt_on_ls    = on_ls_ff;
      nxt_passive  = passive_ff;
      nxt_offseq   = offseq_ff;
      nxt_fwpend   = fwpend_ff;
      nxt_lvl      = lvl_ff;
      nxt_pre_lvl  = adapt_on ? pre_lvl_ff : levels[g].pre_init;
      nxt_pdis_lvl = adapt_on ? pdis_lvl_ff : levels[g].pdis_init;
      if (!gate_supply_on) begin
        nxt_st      = HBGS_S_HOLD;
        nxt_on_hs   = 1'b0;
        nxt_on_ls   = 1'b0;
        nxt_passive = 1'b1;
        nxt_fwpend  = 1'b0;
      end else if (cmd_ev_ff) begin
        nxt_fwpend = 1'b0;
        if (!mode_on) begin
          nxt_st     = HBGS_S_CCP;
          nxt_cnt    = dur_ccp;
          nxt_offseq = 1'b1;
        end else if (bridge_pulse_drive_on[g]) begin
          // Pulse drive waits for the next input edge with both gates held off
          nxt_st      = HBGS_S_HOLD;
          nxt_on_hs   = 1'b0;
          nxt_on_ls   = 1'b0;
          nxt_passive = 1'b0;
          nxt_side    = pwm_side;
        end else begin
          nxt_side    = pwm_side;
          nxt_offseq  = 1'b0;
          nxt_passive = 1'b0;
          if (cmd_opp) begin
            nxt_st  = HBGS_S_CCP;
            nxt_cnt = dur_ccp;
          end else begin
            nxt_st  = HBGS_S_CHG;
            nxt_cnt = dur_chg;
          end
        end
      end else if (p_rise) begin
        nxt_side   = act_side;
        nxt_offseq = 1'b0;
        nxt_fwpend = 1'b0;
        nxt_lvl    = levels[g].chg;
        if (active_freewheel_on[g] && opp_on) begin
          nxt_st  = HBGS_S_CCP;
          nxt_cnt = dur_ccp;
        end else if (pre_on) begin
          nxt_st  = HBGS_S_PRE;
          nxt_cnt = dur_pre;
        end else begin
          nxt_st  = HBGS_S_CHG;
          nxt_cnt = dur_blank;
        end
      end else if (p_fall) begin
        nxt_side = pwm_side;
        if (pre_on) begin
          nxt_st  = HBGS_S_PDIS;
          nxt_cnt = dur_pdis;
        end else begin
          nxt_st  = HBGS_S_DIS;
          nxt_cnt = dur_blank;
        end
      end else begin
        unique case (st_ff)
          HBGS_S_HOLD: begin
          end
          HBGS_S_CCP: begin
            if (done) begin
              if (offseq_ff) begin
                nxt_st      = HBGS_S_HOLD;
                nxt_on_hs   = fwpend_ff & ~side_ff;
                nxt_on_ls   = fwpend_ff & side_ff;
                nxt_passive = (mode == HBGS_MODE_PASSIVE) & ~fwpend_ff;
                nxt_lvl     = levels[g].chg;
                nxt_fwpend  = 1'b0;
              end else if (pwm_mode && pre_on) begin
                nxt_st    = HBGS_S_PRE;
                nxt_cnt   = dur_pre;
                nxt_on_hs = 1'b0;
                nxt_on_ls = 1'b0;
              end else begin
                nxt_st    = HBGS_S_CHG;
                nxt_cnt   = pwm_mode ? dur_blank : dur_chg;
                nxt_on_hs = 1'b0;
                nxt_on_ls = 1'b0;
              end
            end
          end
          HBGS_S_PRE: begin
            if (done) begin
              nxt_st      = HBGS_S_CHG;
              nxt_cnt     = dur_blank;
              nxt_pre_lvl = adapt_on ? (on_late_s[g] ? pre_up : pre_dn) : levels[g].pre_init;
            end
          end
          HBGS_S_CHG: begin
            if (done) begin
              nxt_on_hs = side_ff;
              nxt_on_ls = ~side_ff;
              nxt_lvl   = levels[g].chg;
              nxt_st    = (pwm_mode && !postcharge_off) ? HBGS_S_POST : HBGS_S_HOLD;
            end
          end
          HBGS_S_POST: begin
            if (lvl_ff >= max_lvl) begin
              nxt_st = HBGS_S_HOLD;
            end else if (bd_tick_ff) begin
              nxt_lvl = lvl_ff + HBGS_LVL_STEP;
            end
          end
          HBGS_S_PDIS: begin
            if (done) begin
              nxt_st       = HBGS_S_DIS;
              nxt_cnt      = dur_blank;
              nxt_pdis_lvl = adapt_on ? (off_late_s[g] ? pdis_up : pdis_dn) : levels[g].pdis_init;
            end
          end
          HBGS_S_DIS: begin
            if (done) begin
              nxt_on_hs = 1'b0;
              nxt_on_ls = 1'b0;
              if (afw_eff) begin
                nxt_st     = HBGS_S_CCP;
                nxt_cnt    = dur_ccp;
                nxt_offseq = 1'b1;
                nxt_fwpend = 1'b1;
              end else begin
                nxt_st = HBGS_S_HOLD;
              end
            end
          end
          default: begin
            nxt_st = HBGS_S_HOLD;
          end
        endcase
      end
    end

    // Drive currents for the gate being switched and its partner
    always_comb begin
      on_drv  = '{dir: HBGS_DRV_SINK, lvl: hold_lvl};
      off_drv = '{dir: HBGS_DRV_SINK, lvl: hold_lvl};
      nxt_hs  = '{dir: HBGS_DRV_SINK, lvl: hold_lvl};
      nxt_ls  = '{dir: HBGS_DRV_SINK, lvl: hold_lvl};
      unique case (nxt_st)
        HBGS_S_CCP: begin
          on_drv  = '{dir: HBGS_DRV_SINK, lvl: st_lvl};
          off_drv = '{dir: HBGS_DRV_SINK, lvl: st_lvl};
        end
        HBGS_S_PRE: begin
          on_drv  = '{dir: HBGS_DRV_SOURCE, lvl: pre_cur};
          off_drv = '{dir: HBGS_DRV_SINK, lvl: HBGS_LVL_HARD_OFF};
        end
        HBGS_S_CHG: begin
          on_drv  = '{dir: HBGS_DRV_SOURCE, lvl: pwm_mode ? levels[g].chg : st_lvl};
          off_drv = '{dir: HBGS_DRV_SINK, lvl: HBGS_LVL_HARD_OFF};
        end
        HBGS_S_POST: begin
          on_drv  = '{dir: HBGS_DRV_SOURCE, lvl: nxt_lvl};
          off_drv = '{dir: HBGS_DRV_SINK, lvl: HBGS_LVL_HARD_OFF};
        end
        HBGS_S_PDIS: begin
          on_drv  = '{dir: HBGS_DRV_SINK, lvl: pdis_cur};
        end
        HBGS_S_DIS: begin
          on_drv  = '{dir: HBGS_DRV_SINK, lvl: levels[g].chg};
        end
        default: begin
        end
      endcase
      if (nxt_st == HBGS_S_HOLD) begin
        // Static hold uses the hold step; pulse drive keeps the reached level
        if (nxt_passive) begin
          nxt_hs = HBGS_DRIVE_RST;
          nxt_ls = HBGS_DRIVE_RST;
        end else begin
          if (nxt_on_hs) begin
            nxt_hs = '{dir: HBGS_DRV_SOURCE, lvl: bridge_pulse_drive_on[g] ? nxt_lvl : hold_lvl};
          end
          if (nxt_on_ls) begin
            nxt_ls = '{dir: HBGS_DRV_SOURCE, lvl: bridge_pulse_drive_on[g] ? nxt_lvl : hold_lvl};
          end
        end
      end else begin
        nxt_hs = nxt_side ? on_drv : off_drv;
        nxt_ls = nxt_side ? off_drv : on_drv;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        st_ff       <= HBGS_S_HOLD;
        cnt_ff      <= HBGS_CNT_RST;
        side_ff     <= 1'b0;
        on_hs_ff    <= 1'b0;
        on_ls_ff    <= 1'b0;
        passive_ff  <= 1'b1;
        offseq_ff   <= 1'b0;
        fwpend_ff   <= 1'b0;
        lvl_ff      <= HBGS_LVL_MIN;
        pre_lvl_ff  <= HBGS_LVL_MIN;
        pdis_lvl_ff <= HBGS_LVL_MIN;
        pulse_d_ff  <= 1'b0;
        hs_ff       <= HBGS_DRIVE_RST;
        ls_ff       <= HBGS_DRIVE_RST;
        busy_ff     <= 1'b0;
      end else begin
        st_ff       <= nxt_st;
        cnt_ff      <= nxt_cnt;
        side_ff     <= nxt_side;
        on_hs_ff    <= nxt_on_hs;
        on_ls_ff    <= nxt_on_ls;
        passive_ff  <= nxt_passive;
        offseq_ff   <= nxt_offseq;
        fwpend_ff   <= nxt_fwpend;
        lvl_ff      <= nxt_lvl;
        pre_lvl_ff  <= nxt_pre_lvl;
        pdis_lvl_ff <= nxt_pdis_lvl;
        pulse_d_ff  <= pulse_s[g];
        hs_ff       <= nxt_hs;
        ls_ff       <= nxt_ls;
        busy_ff     <= nxt_st != HBGS_S_HOLD;
      end
    end

    assign hs_drive[g]      = hs_ff;
    assign ls_drive[g]      = ls_ff;
    assign sequence_busy[g] = busy_ff;
  end

endmodule // hbgs_sequencer

// *** src/hbgs_pkg.sv ***
// Constants, carrier structs and state codes of the half-bridge gate sequencer
package hbgs_pkg;

  // Geometry
  localparam int HBGS_NHB    = 3;
  localparam int HBGS_LVL_W  = 6;
  localparam int HBGS_TIME_W = 8;
  localparam int HBGS_CNT_W  = HBGS_TIME_W + 1;
  localparam int HBGS_BD_W   = 4;

  // Clock and command latency
  localparam int HBGS_CLK_PERIOD_NS = 40;
  localparam int HBGS_CMD_DELAY_NS  = 3000;
  localparam int HBGS_CMD_DELAY_CYC = HBGS_CMD_DELAY_NS / HBGS_CLK_PERIOD_NS;
  localparam int HBGS_CMD_LAT_CYC   = 5;

  // Current step codes on the 6-bit drive scale
  localparam logic [HBGS_LVL_W-1:0] HBGS_LVL_HARD_OFF  = 6'h3f;
  localparam logic [HBGS_LVL_W-1:0] HBGS_LVL_HOLD_LOW  = 6'h0f;
  localparam logic [HBGS_LVL_W-1:0] HBGS_LVL_HOLD_HIGH = 6'h14;
  localparam logic [HBGS_LVL_W-1:0] HBGS_LVL_MIN       = 6'h00;
  localparam logic [HBGS_LVL_W-1:0] HBGS_LVL_STEP      = 6'h01;
  localparam logic [1:0]            HBGS_STATIC_PAD    = 2'h0;

  // Bridge state select codes
  localparam logic [1:0] HBGS_MODE_PASSIVE = 2'h0;
  localparam logic [1:0] HBGS_MODE_LS_ON   = 2'h1;
  localparam logic [1:0] HBGS_MODE_HS_ON   = 2'h2;
  localparam logic [1:0] HBGS_MODE_ACT_OFF = 2'h3;

  // Gate control scheme
  localparam logic [1:0] HBGS_GCS_NONE   = 2'h0;
  localparam int         HBGS_GCS_ADAPT  = 1;

  // Reset values
  localparam logic [HBGS_CNT_W-1:0] HBGS_CNT_RST = 9'h000;
  localparam logic [HBGS_CNT_W-1:0] HBGS_CNT_ONE = 9'h001;
  localparam logic [HBGS_BD_W-1:0]  HBGS_BD_RST  = 4'h0;

  typedef enum logic [1:0] {
    HBGS_DRV_PASSIVE = 2'h0,
    HBGS_DRV_SOURCE  = 2'h1,
    HBGS_DRV_SINK    = 2'h2
  } hbgs_dir_e;

  typedef struct packed {
    hbgs_dir_e             dir;
    logic [HBGS_LVL_W-1:0] lvl;
  } hbgs_drive_s;

  typedef struct packed {
    logic [HBGS_TIME_W-1:0] ccp;
    logic [HBGS_TIME_W-1:0] blank;
    logic [HBGS_TIME_W-1:0] filter;
    logic [HBGS_TIME_W-1:0] pre;
    logic [HBGS_TIME_W-1:0] pdis;
  } hbgs_timing_s;

  typedef struct packed {
    logic [HBGS_LVL_W-1:0] chg;
    logic [HBGS_LVL_W-1:0] max;
    logic [HBGS_LVL_W-1:0] pre_init;
    logic [HBGS_LVL_W-1:0] pdis_init;
  } hbgs_level_s;

  typedef enum logic [6:0] {
    HBGS_S_HOLD = 7'h01,
    HBGS_S_CCP  = 7'h02,
    HBGS_S_PRE  = 7'h04,
    HBGS_S_CHG  = 7'h08,
    HBGS_S_POST = 7'h10,
    HBGS_S_PDIS = 7'h20,
    HBGS_S_DIS  = 7'h40
  } hbgs_state_e;

  localparam hbgs_drive_s HBGS_DRIVE_RST = '{dir: HBGS_DRV_PASSIVE, lvl: HBGS_LVL_MIN};

endpackage

// *** bench/hbgs_fet_model.sv ***
// Behavioural power stage: the switch node follows whichever gate is sourced
`timescale 1ns/1ps
module hbgs_fet_model
  import hbgs_pkg::*;
#(
  parameter int NHB = HBGS_NHB
) (
  // Gate drives
  input  wire hbgs_drive_s  hs_drive [NHB],
  input  wire hbgs_drive_s  ls_drive [NHB],
  // Comparator pins
  output logic [NHB-1:0]    switch_node_high,
  output logic [NHB-1:0]    switch_node_low,
  output logic [NHB-1:0]    turn_on_late,
  output logic [NHB-1:0]    turn_off_late
);
  // Node rests between thresholds while neither side conducts
  for (genvar i = 0; i < NHB; i++) begin : g_leg
    assign switch_node_high[i] = hs_drive[i].dir == HBGS_DRV_SOURCE && ls_drive[i].dir != HBGS_DRV_SOURCE;
    assign switch_node_low[i]  = ls_drive[i].dir == HBGS_DRV_SOURCE && hs_drive[i].dir != HBGS_DRV_SOURCE;
  end
  // Never late: adaptive currents walk down one step per phase
  assign turn_on_late  = '0;
  assign turn_off_late = '0;
endmodule // hbgs_fet_model

// *** bench/hbgs_sequencer_checker.sv ***
// Port-level assertions for the gate sequencer, bridge 0
`timescale 1ns/1ps
module hbgs_sequencer_checker
  import hbgs_pkg::*;
#(
  parameter int NHB = HBGS_NHB
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rst_b,
  // Command and configuration
  input wire logic           cs_b,
  input wire logic           gate_supply_on,
  input wire logic           hold_current_sel,
  input wire logic [NHB-1:0] bridge_pulse_drive_on,
  // Drives
  input wire hbgs_drive_s    hs_drive [NHB],
  input wire hbgs_drive_s    ls_drive [NHB],
  input wire logic [NHB-1:0] sequence_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire [HBGS_LVL_W-1:0] hold_lvl = hold_current_sel ? HBGS_LVL_HOLD_HIGH : HBGS_LVL_HOLD_LOW;
  wire hs_src  = hs_drive[0].dir == HBGS_DRV_SOURCE;
  wire ls_src  = ls_drive[0].dir == HBGS_DRV_SOURCE;
  wire hs_snk  = hs_drive[0].dir == HBGS_DRV_SINK;
  wire ls_snk  = ls_drive[0].dir == HBGS_DRV_SINK;
  // Pulse drive keeps other levels in hold, so only static settling counts
  wire settled = !sequence_busy[0] && !bridge_pulse_drive_on[0] && gate_supply_on;
  no_dual_source_a: assert property (!(hs_src && ls_src))
    else $error("both gates sourced");
  hs_hard_off_a: assert property (ls_snk && ls_drive[0].lvl == HBGS_LVL_HARD_OFF |-> hs_src)
    else $error("hard off without high side charge");
  ls_hard_off_a: assert property (hs_snk && hs_drive[0].lvl == HBGS_LVL_HARD_OFF |-> ls_src)
    else $error("hard off without low side charge");
  supply_off_a: assert property (!gate_supply_on |=> !hs_src && !hs_snk && !ls_src && !ls_snk)
    else $error("gates driven with supply off");
  cmd_latency_a: assert property ($rose(cs_b) && gate_supply_on && !bridge_pulse_drive_on[0] |-> ##[1:6] sequence_busy[0])
    else $error("command not applied in time");
  hold_on_a: assert property (settled && $stable(hold_current_sel) && hs_src |-> hs_drive[0].lvl == hold_lvl)
    else $error("on gate not at hold level");
  hold_off_a: assert property (settled && $stable(hold_current_sel) && hs_snk |-> hs_drive[0].lvl == hold_lvl)
    else $error("off gate not at hold level");
  ccp_equal_a: assert property (sequence_busy[0] && hs_snk && ls_snk && settled == 1'b0 |-> hs_drive[0].lvl == ls_drive[0].lvl)
    else $error("protection sink levels differ");
  ccp_seen_c: cover property (sequence_busy[0] && hs_snk && ls_snk);
  hard_off_c: cover property (ls_snk && ls_drive[0].lvl == HBGS_LVL_HARD_OFF);
  supply_c: cover property (!gate_supply_on);
endmodule // hbgs_sequencer_checker
bind hbgs_sequencer hbgs_sequencer_checker #(.NHB(NHB)) hbgs_sequencer_checker_i (.clk, .rst_b, .cs_b, .gate_supply_on,
  .hold_current_sel, .bridge_pulse_drive_on, .hs_drive, .ls_drive, .sequence_busy);

// *** bench/tb_hbgs_sequencer.sv ***
// Self-checking bench for the half-bridge gate sequencer
`timescale 1ns/1ps
module tb_hbgs_sequencer
  import hbgs_pkg::*;
;
  localparam int N = HBGS_NHB;
  localparam hbgs_dir_e SRC = HBGS_DRV_SOURCE;
  localparam hbgs_dir_e SNK = HBGS_DRV_SINK;
  logic clk = 1'b0, rst_b = 1'b0, cs_b = 1'b1, gate_supply_on = 1'b1, hold_current_sel = 1'b0;
  logic active_freewheel_detect_on = 1'b1, pulse_input_count_sel = 1'b0, postcharge_off = 1'b0;
  logic [1:0] gate_control_scheme = 2'h0, bridge_driver_clock_sel = 2'h0;
  logic [1:0] bridge_state_select [N];
  logic [N-1:0] bridge_pulse_drive_on = N'(2), active_freewheel_on = '0, pulse_in = '0;
  logic [3:0] static_drive_current_sel [N];
  hbgs_timing_s timing [N];
  hbgs_level_s levels [N];
  hbgs_drive_s hs_drive [N], ls_drive [N];
  wire logic [N-1:0] switch_node_high, switch_node_low, turn_on_late, turn_off_late, sequence_busy;
  int error_cnt = 0, cmp_count = 0;
  always #20 clk = ~clk;
  hbgs_sequencer #(.NHB(N)) hbgs_sequencer_i (.clk, .rst_b, .cs_b, .gate_supply_on, .hold_current_sel,
    .active_freewheel_detect_on, .pulse_input_count_sel, .postcharge_off, .gate_control_scheme,
    .bridge_driver_clock_sel, .bridge_state_select, .bridge_pulse_drive_on, .active_freewheel_on,
    .static_drive_current_sel, .timing, .levels, .pulse_in, .switch_node_high, .switch_node_low,
    .turn_on_late, .turn_off_late, .hs_drive, .ls_drive, .sequence_busy);
  hbgs_fet_model #(.NHB(N)) hbgs_fet_model_i (.hs_drive, .ls_drive, .switch_node_high, .switch_node_low,
    .turn_on_late, .turn_off_late);
  function automatic hbgs_drive_s dv(hbgs_dir_e d, logic [5:0] l);
    return '{dir: d, lvl: l};
  endfunction
  function automatic bit hit(int b, hbgs_drive_s h, hbgs_drive_s l, bit cl);
    return hs_drive[b] === h && (!cl || ls_drive[b] === l);
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Waits for a drive pattern, then measures how long it stands
  task automatic phase(int b, hbgs_drive_s h, hbgs_drive_s l, bit cl, int len, int bound);
    int w;
    int n;
    w = 0;
    n = 0;
    while (!hit(b, h, l, cl) && w < bound) begin
      tick();
      w++;
    end
    if (!hit(b, h, l, cl)) begin
      error_cnt++;
      check(hs_drive[b], h);
      conclude();
    end
    while (len > 0 && hit(b, h, l, cl) && n < 600) begin
      tick();
      n++;
    end
    if (len > 0) check(n, len);
  endtask
  task automatic cmd(logic [1:0] m);
    bridge_state_select[0] = m;
    cs_b = 1'b0;
    tick();
    cs_b = 1'b1;
  endtask
  task automatic s_static(logic [3:0] sel, logic hsel);
    hbgs_drive_s ss, sk, hs, hk, hd;
    hold_current_sel = hsel;
    foreach (static_drive_current_sel[i]) static_drive_current_sel[i] = sel;
    ss = dv(SRC, {sel, HBGS_STATIC_PAD});
    sk = dv(SNK, {sel, HBGS_STATIC_PAD});
    hs = dv(SRC, hsel ? HBGS_LVL_HOLD_HIGH : HBGS_LVL_HOLD_LOW);
    hk = dv(SNK, hsel ? HBGS_LVL_HOLD_HIGH : HBGS_LVL_HOLD_LOW);
    hd = dv(SNK, HBGS_LVL_HARD_OFF);
    tick();
    cmd(HBGS_MODE_ACT_OFF);
    phase(0, sk, sk, 1, 6, 8);
    phase(0, hk, hk, 1, 0, 8);
    cmd(HBGS_MODE_HS_ON);
    phase(0, ss, hd, 1, 8, 6);
    phase(0, hs, hk, 1, 0, 8);
    cmd(HBGS_MODE_LS_ON);
    phase(0, sk, sk, 1, 6, 8);
    phase(0, hd, ss, 1, 8, 8);
    phase(0, hk, hs, 1, 0, 8);
    cmd(HBGS_MODE_HS_ON);
    phase(0, sk, sk, 1, 6, 8);
    phase(0, ss, hd, 1, 8, 8);
    phase(0, hs, hk, 1, 0, 8);
    cmd(HBGS_MODE_PASSIVE);
    phase(0, sk, sk, 1, 6, 8);
    phase(0, HBGS_DRIVE_RST, HBGS_DRIVE_RST, 1, 0, 8);
  endtask
  task automatic s_supply();
    cmd(HBGS_MODE_HS_ON);
    repeat (20) tick();
    gate_supply_on = 1'b0;
    repeat (2) tick();
    check(hs_drive[0], HBGS_DRIVE_RST);
    check(ls_drive[0], HBGS_DRIVE_RST);
    gate_supply_on = 1'b1;
    cmd(HBGS_MODE_PASSIVE);
    repeat (12) tick();
  endtask
  // Bridge 1 in pulse drive, node mid-rail so the selected high side is active
  // With post-charge off the on gate stays at the charge level into hold, so the charge phase length is measured on busy
  task automatic s_pulse(logic [1:0] s, logic po, logic [5:0] pre, logic [5:0] pdis);
    hbgs_drive_s hk;
    int n;
    hk = dv(SNK, hold_current_sel ? HBGS_LVL_HOLD_HIGH : HBGS_LVL_HOLD_LOW);
    n = 0;
    gate_control_scheme = s;
    postcharge_off = po;
    pulse_in[1] = 1'b1;
    if (s != HBGS_GCS_NONE) phase(1, dv(SRC, pre), dv(SNK, HBGS_LVL_HARD_OFF), 1, 3, 8);
    phase(1, dv(SRC, levels[1].chg), hk, 0, 0, 8);
    while (po && sequence_busy[1] && n < 16) begin
      tick();
      n++;
    end
    if (po) check(n, timing[1].blank);
    repeat (26) tick();
    check(hs_drive[1], dv(SRC, po ? levels[1].chg : levels[1].max));
    pulse_in[1] = 1'b0;
    if (s != HBGS_GCS_NONE) phase(1, dv(SNK, pdis), hk, 1, 2, 8);
    phase(1, dv(SNK, levels[1].chg), hk, 0, 5, 8);
    phase(1, hk, hk, 1, 0, 8);
  endtask
  initial begin
    foreach (timing[i]) begin
      timing[i] = '{ccp: 8'h06, blank: 8'h05, filter: 8'h03, pre: 8'h03, pdis: 8'h02};
      levels[i] = '{chg: 6'h10, max: 6'h18, pre_init: 6'h08, pdis_init: 6'h0a};
      static_drive_current_sel[i] = 4'h3;
      bridge_state_select[i] = (i == 1) ? HBGS_MODE_HS_ON : HBGS_MODE_PASSIVE;
    end
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) tick();
    s_static(4'h3, 1'b0);
    s_static(4'hf, 1'b1);
    s_supply();
    s_pulse(2'h1, 1'b0, levels[1].pre_init, levels[1].pdis_init);
    s_pulse(2'h2, 1'b0, levels[1].pre_init, levels[1].pdis_init);
    s_pulse(2'h2, 1'b0, levels[1].pre_init - HBGS_LVL_STEP, levels[1].pdis_init - HBGS_LVL_STEP);
    s_pulse(2'h0, 1'b1, levels[1].pre_init, levels[1].pdis_init);
    conclude();
  end
endmodule // tb_hbgs_sequencer
